/* File: src/stack_pointer_limit_check.sv */
// Stack pointer update, program counter push formatting and stack limit trap detection.
//
// Operation
// - Working register fifteen acts both as an ordinary register and as the stack pointer.
// - The pointer always addresses the next free word and the stack grows upward.
// - A push writes at the pointer then increments it, a pop decrements it first then reads.
// - A call pushes the program counter with its upper pushed part zero-filled so its top bit is clear.
// - An exception pushes the program counter with the low status byte joined to its upper part.
// - The stack limit register has no defined reset value and software must load it first.
// - Bit zero of the stack limit register reads and acts as zero once the limit has been loaded.
// - Outside a push or pop, every effective address formed through register fifteen is compared with the limit.
// - A push at a pointer equal to the limit is fine, and the next push beyond it traps.
// - A stack address below 0x0800 raises the stack error trap for underflow.
`timescale 1ns/1ps

module stack_pointer_limit_check
	import stack_limit_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire stack_op_t             stack_op,
	input  wire push_fmt_t             push_fmt,
	input  wire logic [WORD_W-1:0]     push_data,
	input  wire logic [PC_W-1:0]       pc_value,
	input  wire logic [SR_LOW_W-1:0]   status_low_byte,
	input  wire logic [WORD_W-1:0]     sp_load_value,
	input  wire logic                  ea_valid,
	input  wire logic [3:0]            ea_reg_index,
	input  wire logic [WORD_W-1:0]     ea_address,
	input  wire logic                  limit_write,
	input  wire logic [WORD_W-1:0]     limit_write_data,
	output logic [WORD_W-1:0]          stack_pointer_working_reg,
	output logic [WORD_W-1:0]          stack_limit_reg,
	output logic [WORD_W-1:0]          stack_mem_addr,
	output logic [WORD_W-1:0]          stack_push_word_lo,
	output logic [WORD_W-1:0]          stack_push_word_hi,
	output logic                       stack_write,
	output logic                       stack_read,
	output logic                       stack_error_trap,
	output logic                       stack_overflow,
	output logic                       stack_underflow
);

	// ****************************************************************
	// Stack pointer
	// ****************************************************************

	logic [WORD_W-1:0] sp_r;
	logic [WORD_W-1:0] sp_nxt;
	logic [WORD_W-1:0] sp_up;
	logic [WORD_W-1:0] sp_down;

	// Both neighbours of the pointer are formed once; the lower one is shared by the update, the access and the check, the upper one feeds only the update.
	always_comb
	begin
		sp_up   = sp_r + WORD_STEP;
		sp_down = sp_r - WORD_STEP;
	end

	// The pointer is word aligned like the limit, so a stray load cannot misalign the stack.
	always_comb
	begin
		sp_nxt = sp_r;
		case (stack_op)
			STK_PUSH:
			begin
				sp_nxt = sp_up;
			end
			STK_POP:
			begin
				sp_nxt = sp_down;
			end
			STK_LOAD:
			begin
				sp_nxt = sp_load_value & ALIGN_MASK;
			end
			default:
			begin
				sp_nxt = sp_r;
			end
		endcase
	end

	// The reset value sits at the bottom of the usable stack, so a pop straight after reset trips underflow.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sp_r <= SP_RESET_VALUE;
		end
		else
		begin
			sp_r <= sp_nxt;
		end
	end

	// ****************************************************************
	// Stack access address and strobes
	// ****************************************************************

	logic [WORD_W-1:0] addr_r;
	logic [WORD_W-1:0] addr_nxt;
	logic              wr_r;
	logic              wr_nxt;
	logic              rd_r;
	logic              rd_nxt;

	// The address holds after the access so the last stack slot stays visible.
	// The strobes are single pulses, one per push or pop.
	always_comb
	begin
		addr_nxt = addr_r;
		wr_nxt   = 1'b0;
		rd_nxt   = 1'b0;
		if (stack_op == STK_PUSH)
		begin
			addr_nxt = sp_r;
			wr_nxt   = 1'b1;
		end
		else if (stack_op == STK_POP)
		begin
			addr_nxt = sp_down;
			rd_nxt   = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			addr_r <= '0;
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
		end
		else
		begin
			addr_r <= addr_nxt;
			wr_r   <= wr_nxt;
			rd_r   <= rd_nxt;
		end
	end

	// ****************************************************************
	// Pushed words
	// ****************************************************************

	logic [WORD_W-1:0] lo_r;
	logic [WORD_W-1:0] lo_nxt;
	logic [WORD_W-1:0] hi_r;
	logic [WORD_W-1:0] hi_nxt;

	// The upper word keeps only the program counter bits above the low word; its top byte is zeros or status.
	// A data push clears the upper word so a stale return address never lingers there.
	always_comb
	begin
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		if (stack_op == STK_PUSH)
		begin
			case (push_fmt)
				PC_FMT_CALL:
				begin
					lo_nxt = pc_value[WORD_W-1:0];
					hi_nxt = {PUSH_HI_W'(0), 1'b0, pc_value[PC_W-1:WORD_W]};
				end
				PC_FMT_EXC:
				begin
					lo_nxt = pc_value[WORD_W-1:0];
					hi_nxt = {status_low_byte, 1'b0, pc_value[PC_W-1:WORD_W]};
				end
				default:
				begin
					lo_nxt = push_data;
					hi_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			lo_r <= '0;
			hi_r <= '0;
		end
		else
		begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end

	// ****************************************************************
	// Stack limit register
	// ****************************************************************

	// The limit is deliberately left out of reset; software must load it before relying on the check.
	logic [WORD_W-1:0] lim_r;
	logic [WORD_W-1:0] lim_nxt;

	always_comb
	begin
		lim_nxt = lim_r;
		if (limit_write)
		begin
			lim_nxt = limit_write_data & ALIGN_MASK;
		end
	end

	// A check sampled on the same edge as a limit write still compares against the old limit.
	always_ff @(posedge clk_sys)
	begin
		lim_r <= lim_nxt;
	end

	// ****************************************************************
	// Limit and underflow check
	// ****************************************************************

	logic              sp_ea_hit;
	logic              chk_en;
	logic [WORD_W-1:0] chk_addr;
	logic              over_nxt;
	logic              under_nxt;
	logic              trap_nxt;
	logic              over_r;
	logic              under_r;
	logic              trap_r;

	// A push checks the address it writes to, so a push at the limit itself passes.
	// During a push or pop the pointer's own access is checked, not the effective-address port.
	always_comb
	begin
		sp_ea_hit = ea_valid && (ea_reg_index == SP_REG_INDEX);
		chk_en    = 1'b0;
		chk_addr  = ea_address;
		case (stack_op)
			STK_PUSH:
			begin
				chk_en   = 1'b1;
				chk_addr = sp_r;
			end
			STK_POP:
			begin
				chk_en   = 1'b1;
				chk_addr = sp_down;
			end
			default:
			begin
				chk_en   = sp_ea_hit;
				chk_addr = ea_address;
			end
		endcase
	end

	// Until the limit is loaded the overflow result is undefined, the price of leaving it out of reset.
	always_comb
	begin
		over_nxt  = 1'b0;
		under_nxt = 1'b0;
		if (chk_en)
		begin
			over_nxt  = chk_addr > lim_r;
			under_nxt = chk_addr < SP_UNDERFLOW_LIM;
		end
		trap_nxt = over_nxt || under_nxt;
	end

	// The cause flags share the trap's timing so the exception logic reads the cause with the request.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			over_r  <= 1'b0;
			under_r <= 1'b0;
			trap_r  <= 1'b0;
		end
		else
		begin
			over_r  <= over_nxt;
			under_r <= under_nxt;
			trap_r  <= trap_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	assign stack_pointer_working_reg = sp_r;
	assign stack_limit_reg           = lim_r;
	assign stack_mem_addr            = addr_r;
	assign stack_push_word_lo        = lo_r;
	assign stack_push_word_hi        = hi_r;
	assign stack_write               = wr_r;
	assign stack_read                = rd_r;
	assign stack_error_trap          = trap_r;
	assign stack_overflow            = over_r;
	assign stack_underflow           = under_r;

endmodule

/* File: src/stack_limit_pkg.sv */
// Constants and types shared by the software stack limit checker.
package stack_limit_pkg;
	localparam int unsigned WORD_W          = 16;
	localparam int unsigned PC_W            = 23;
	localparam int unsigned SR_LOW_W        = 8;
	localparam int unsigned PUSH_HI_W       = 8;
	localparam logic [15:0] SP_UNDERFLOW_LIM = 16'h0800;
	localparam logic [15:0] WORD_STEP        = 16'h0002;
	localparam logic [15:0] ALIGN_MASK       = 16'hfffe;
	localparam logic [15:0] SP_RESET_VALUE   = 16'h0800;
	localparam logic [3:0]  SP_REG_INDEX     = 4'hf;

	typedef enum logic [1:0]
	{
		STK_IDLE = 2'b00,
		STK_PUSH = 2'b01,
		STK_POP  = 2'b10,
		STK_LOAD = 2'b11
	} stack_op_t;

	typedef enum logic [1:0]
	{
		PC_FMT_CALL = 2'b00,
		PC_FMT_EXC  = 2'b01,
		PC_FMT_DATA = 2'b10
	} push_fmt_t;
endpackage

/* File: verification/stack_trap_sink.sv */
// Exception-side model that takes stack error trap requests.
`timescale 1ns/1ps
module stack_trap_sink
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic stack_error_trap,
	output int        trap_count
);
	// Each cycle high is one request, so a trap held high would be counted once for every cycle it stays high.
	always_ff @(posedge clk_sys)
		trap_count <= reset ? 0 : trap_count + int'(stack_error_trap);
endmodule

/* File: verification/stack_pointer_limit_check_assertions.sv */
// Port checks for the stack limit checker.
`timescale 1ns/1ps
module stack_limit_assertions
	import stack_limit_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire stack_op_t   stack_op,
	input wire push_fmt_t   push_fmt,
	input wire logic [22:0] pc_value,
	input wire logic [7:0]  status_low_byte,
	input wire logic        limit_write,
	input wire logic [15:0] limit_write_data,
	input wire logic        ea_valid,
	input wire logic [3:0]  ea_reg_index,
	input wire logic [15:0] ea_address,
	input wire logic [15:0] stack_pointer_working_reg,
	input wire logic [15:0] stack_limit_reg,
	input wire logic [15:0] stack_mem_addr,
	input wire logic [15:0] stack_push_word_hi,
	input wire logic        stack_write,
	input wire logic        stack_read,
	input wire logic        stack_error_trap
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire [15:0] sp = stack_pointer_working_reg;
	wire        pu = stack_op == STK_PUSH;
	wire        po = stack_op == STK_POP;
	property p_push; pu |=> sp == $past(sp) + WORD_STEP && stack_mem_addr == $past(sp); endproperty
	a_push: assert property (p_push) else $error("push step");
	property p_pop; po |=> sp == $past(sp) - WORD_STEP && stack_mem_addr == sp; endproperty
	a_pop: assert property (p_pop) else $error("pop step");
	property p_call; pu && push_fmt == PC_FMT_CALL |=> stack_push_word_hi == {9'h0, $past(pc_value[22:16])}; endproperty
	a_call: assert property (p_call) else $error("call word");
	property p_exc; pu && push_fmt == PC_FMT_EXC |=>
		stack_push_word_hi == {$past(status_low_byte), 1'b0, $past(pc_value[22:16])}; endproperty
	a_exc: assert property (p_exc) else $error("exception word");
	property p_lim; limit_write |=> stack_limit_reg == ($past(limit_write_data) & ALIGN_MASK); endproperty
	a_lim: assert property (p_lim) else $error("limit value");
	property p_ovf; pu && sp > stack_limit_reg |=> stack_error_trap; endproperty
	a_ovf: assert property (p_ovf) else $error("no overflow trap");
	property p_eq; pu && sp == stack_limit_reg && sp >= SP_UNDERFLOW_LIM |=> !stack_error_trap; endproperty
	a_eq: assert property (p_eq) else $error("trap at limit");
	property p_unf; po && sp - WORD_STEP < SP_UNDERFLOW_LIM |=> stack_error_trap; endproperty
	a_unf: assert property (p_unf) else $error("no underflow trap");
	property p_ea; !pu && !po && ea_valid && ea_reg_index == SP_REG_INDEX && ea_address > stack_limit_reg |=>
		stack_error_trap; endproperty
	a_ea: assert property (p_ea) else $error("no pointer address trap");
	property p_strobe; pu |=> stack_write && !stack_read; endproperty
	a_strobe: assert property (p_strobe) else $error("push strobe");
	cover property (pu && push_fmt == PC_FMT_EXC);
	cover property (po ##1 stack_error_trap);
	cover property (pu ##1 stack_error_trap);
	cover property (ea_valid ##1 stack_error_trap);
endmodule
bind stack_pointer_limit_check stack_limit_assertions chk
(
	.clk_sys                   (clk_sys),
	.reset                     (reset),
	.stack_op                  (stack_op),
	.push_fmt                  (push_fmt),
	.pc_value                  (pc_value),
	.status_low_byte           (status_low_byte),
	.limit_write               (limit_write),
	.limit_write_data          (limit_write_data),
	.ea_valid                  (ea_valid),
	.ea_reg_index              (ea_reg_index),
	.ea_address                (ea_address),
	.stack_pointer_working_reg (stack_pointer_working_reg),
	.stack_limit_reg           (stack_limit_reg),
	.stack_mem_addr            (stack_mem_addr),
	.stack_push_word_hi        (stack_push_word_hi),
	.stack_write               (stack_write),
	.stack_read                (stack_read),
	.stack_error_trap          (stack_error_trap)
);

/* File: verification/stack_pointer_limit_check_test.sv */
// Directed bench for the stack limit checker.
`timescale 1ns/1ps
module stack_pointer_limit_check_test;
	import stack_limit_pkg::*;
	logic clk_sys = 1'b0, reset = 1'b1, limit_write = 1'b0, ea_valid = 1'b0;
	stack_op_t stack_op = STK_IDLE;
	push_fmt_t push_fmt = PC_FMT_DATA;
	logic [15:0] push_data = 16'h0, sp_load_value = 16'h0, limit_write_data = 16'h0, ea_address = 16'h0;
	logic [22:0] pc_value = 23'h7fabcd;
	logic [7:0]  status_low_byte = 8'h5a;
	logic [3:0]  ea_reg_index = 4'h0;
	logic [15:0] stack_pointer_working_reg, stack_limit_reg, stack_mem_addr, stack_push_word_lo, stack_push_word_hi;
	logic        stack_write, stack_read, stack_error_trap, stack_overflow, stack_underflow;
	int          errors = 0, compares = 0, trap_count;
	stack_pointer_limit_check dut (.*);
	stack_trap_sink far (.clk_sys, .reset, .stack_error_trap, .trap_count);
	initial
		forever #10 clk_sys = ~clk_sys;
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Holds the request for exactly one sampling edge, then looks after that edge settled.
	task go(input stack_op_t o, input push_fmt_t f);
		@(posedge clk_sys);
		stack_op <= o;
		push_fmt <= f;
		@(posedge clk_sys);
		stack_op <= STK_IDLE;
		#1;
	endtask
	// Loads the pointer through its ordinary-register path.
	task set_sp(input logic [15:0] v);
		@(posedge clk_sys);
		sp_load_value <= v;
		go(STK_LOAD, PC_FMT_DATA);
	endtask
	// Writes the limit with a one-cycle strobe.
	task set_lim(input logic [15:0] v);
		@(posedge clk_sys);
		limit_write_data <= v;
		limit_write      <= 1'b1;
		@(posedge clk_sys);
		limit_write <= 1'b0;
		#1;
	endtask
	// Presents one effective address for a single sampling edge.
	task drive_ea(input logic [3:0] r, input logic [15:0] a);
		@(posedge clk_sys);
		ea_valid     <= 1'b1;
		ea_reg_index <= r;
		ea_address   <= a;
		@(posedge clk_sys);
		ea_valid <= 1'b0;
		#1;
	endtask
	task t_push_pop;
		@(posedge clk_sys);
		push_data <= 16'h1234;
		go(STK_PUSH, PC_FMT_DATA);
		chk(stack_pointer_working_reg, 16'h0802);
		chk(stack_mem_addr, 16'h0800);
		chk(stack_write, 1'b1);
		chk(stack_push_word_lo, 16'h1234);
		chk(stack_push_word_hi, 16'h0000);
		chk(stack_error_trap, 1'b0);
		go(STK_POP, PC_FMT_DATA);
		chk(stack_pointer_working_reg, 16'h0800);
		chk(stack_mem_addr, 16'h0800);
		chk(stack_read, 1'b1);
		chk(stack_write, 1'b0);
	endtask
	task t_formats;
		go(STK_PUSH, PC_FMT_CALL);
		chk(stack_push_word_hi, 16'h007f);
		chk(stack_push_word_lo, 16'habcd);
		go(STK_PUSH, PC_FMT_EXC);
		chk(stack_push_word_hi, 16'h5a7f);
	endtask
	task t_limit;
		set_sp(16'h0901);
		chk(stack_pointer_working_reg, 16'h0900);
		set_lim(16'h0903);
		chk(stack_limit_reg, 16'h0902);
		go(STK_PUSH, PC_FMT_DATA);
		go(STK_PUSH, PC_FMT_DATA);
		chk(stack_error_trap, 1'b0);
		go(STK_PUSH, PC_FMT_DATA);
		chk({stack_error_trap, stack_overflow}, 2'b11);
	endtask
	task t_under;
		set_sp(16'h0802);
		go(STK_POP, PC_FMT_DATA);
		chk(stack_error_trap, 1'b0);
		chk(stack_mem_addr, 16'h0800);
		go(STK_POP, PC_FMT_DATA);
		chk({stack_error_trap, stack_underflow}, 2'b11);
	endtask
	task t_ea;
		drive_ea(4'hf, 16'h0904);
		chk({stack_error_trap, stack_overflow}, 2'b11);
		drive_ea(4'he, 16'h0904);
		chk(stack_error_trap, 1'b0);
		drive_ea(4'hf, 16'h0902);
		chk(stack_error_trap, 1'b0);
		drive_ea(4'hf, 16'h07fe);
		chk({stack_error_trap, stack_underflow}, 2'b11);
	endtask
	// Two traps from the stack accesses and two from effective addresses.
	task t_sink;
		go(STK_IDLE, PC_FMT_DATA);
		chk(16'(trap_count), 16'h0004);
	endtask
	task test_done;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		set_lim(16'h0ffe);
		t_push_pop();
		t_formats();
		t_limit();
		t_under();
		t_ea();
		t_sink();
		test_done();
	end
	initial
	begin
		#100000;
		errors++;
		test_done();
	end
endmodule
